/* core/urx_pkg.sv */
// package for the asynchronous receiver: register map, fields, timing
package urx_pkg;
  localparam int CLK_HZ = 40000000;
  localparam logic [2:0] ADDR_BAUD_CTRL = 3'h0;
  localparam logic [2:0] ADDR_RX_DATA = 3'h1;
  localparam logic [2:0] ADDR_RX_STAT = 3'h2;
  localparam logic [2:0] ADDR_DIV_LO = 3'h3;
  localparam logic [2:0] ADDR_DIV_HI = 3'h4;
  localparam logic [2:0] ADDR_TX_STAT = 3'h5;
  localparam logic [2:0] ADDR_IRQ_EN = 3'h6;
  // receive_status_control fields
  localparam int RS_PORT_EN = 7;
  localparam int RS_NINE = 6;
  localparam int RS_SINGLE = 5;
  localparam int RS_RECV_EN = 4;
  localparam int RS_ADDR_DET = 3;
  localparam int RS_FRAME_ERR = 2;
  localparam int RS_OVR_ERR = 1;
  localparam int RS_NINTH = 0;
  // baud_control_reg fields
  localparam int BC_IDLE = 6;
  localparam int BC_WIDE = 3;
  // transmit_status_control fields
  localparam int TS_SYNC = 4;
  localparam int TS_HI_SPEED = 2;
  localparam int TS_TRMT = 1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] TS_RST = 8'h02;
  localparam logic [7:0] BC_WMASK = 8'h08;
  localparam logic [7:0] TS_WMASK = 8'hfd;
  localparam logic [7:0] RS_WMASK = 8'hf8;
  // oversample ticks per bit and sample point
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_HALF = 4'h7;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;
  typedef enum logic [1:0] {URX_IDLE, URX_START, URX_DATA, URX_STOP} urx_state_e;
endpackage : urx_pkg

/* core/urx_receiver.sv */
// asynchronous serial receiver with two-entry fifo, overrun and address detect
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
module urx_receiver
  import urx_pkg::*;
(
  input wire logic i_clk, // 40 MHz clock
  input wire logic i_rst_b, // synchronous reset, active low
  input wire logic i_ce, // clock enable
  input wire logic i_rx, // serial receive line
  input wire logic [2:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [7:0] o_rdata, // read data, cycle after strobe
  output logic o_rx_pending, // receive_pending_flag
  output logic o_rx_irq // interrupt request
);

  typedef struct packed {
    logic [7:0] rs;
    logic [7:0] bc;
    logic [7:0] ts;
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    logic irq_en;
    logic [15:0] brg;
    logic [3:0] ovs;
    logic [3:0] nbit;
    logic [8:0] shreg;
    urx_state_e st;
    logic [1:0][9:0] fifo;
    logic rd_ptr;
    logic [1:0] count;
    logic overrun_error_flag;
    logic [7:0] rdata;
    logic rx_q;
  } urx_s;

  urx_s cur;
  urx_s next_cur;

  logic port_on;
  logic rx_on;
  logic tick;
  logic [15:0] brg_top;
  logic [9:0] head;
  logic push;
  logic pop;
  logic keep;

  // =====================================================================
  // baud tick generation
  always_comb begin
    port_on = cur.rs[RS_PORT_EN] && !cur.ts[TS_SYNC];
    rx_on = port_on && cur.rs[RS_RECV_EN];
    // 16x tick from divisor; wide and speed bits scale the period
    if (cur.bc[BC_WIDE] || cur.ts[TS_HI_SPEED]) begin
      brg_top = {cur.div_hi & {8{cur.bc[BC_WIDE]}}, cur.div_lo};
    end else begin
      brg_top = {6'h00, cur.div_lo, 2'h3};
    end
    tick = (cur.brg == 16'h0000);
    head = cur.fifo[cur.rd_ptr];
  end

  // =====================================================================
  // state update
  always_comb begin
    next_cur = cur;
    push = 1'b0;
    pop = 1'b0;
    keep = 1'b0;
    next_cur.rx_q = i_rx;
    next_cur.brg = tick ? brg_top : cur.brg - 16'h0001;
    // register reads
    next_cur.rdata = RST_BYTE;
    if (i_rd) begin
      unique case (i_addr)
        ADDR_BAUD_CTRL: next_cur.rdata = {1'b0, cur.st == URX_IDLE, 2'b00, cur.bc[BC_WIDE], 3'b000};
        ADDR_RX_DATA: begin
          next_cur.rdata = head[7:0];
          pop = (cur.count != 2'h0);
        end
        ADDR_RX_STAT: next_cur.rdata = {cur.rs[7:3], cur.count != 2'h0 && head[9], cur.overrun_error_flag,
          cur.count != 2'h0 && head[8]};
        ADDR_DIV_LO: next_cur.rdata = cur.div_lo;
        ADDR_DIV_HI: next_cur.rdata = cur.div_hi;
        ADDR_TX_STAT: next_cur.rdata = cur.ts | TS_RST;
        ADDR_IRQ_EN: next_cur.rdata = {7'h00, cur.irq_en};
        default: next_cur.rdata = RST_BYTE;
      endcase
    end
    // register writes
    if (i_wr) begin
      unique case (i_addr)
        ADDR_BAUD_CTRL: next_cur.bc = i_wdata & BC_WMASK;
        ADDR_RX_STAT: next_cur.rs = i_wdata & RS_WMASK;
        ADDR_DIV_LO: begin
          next_cur.div_lo = i_wdata;
          next_cur.brg = 16'h0000;
        end
        ADDR_DIV_HI: begin
          next_cur.div_hi = i_wdata;
          next_cur.brg = 16'h0000;
        end
        ADDR_TX_STAT: next_cur.ts = i_wdata & TS_WMASK;
        ADDR_IRQ_EN: next_cur.irq_en = i_wdata[0];
        default: ;
      endcase
    end
    // receive engine
    if (tick) begin
      next_cur.ovs = cur.ovs + 4'h1;
      unique case (cur.st)
        URX_IDLE: begin
          next_cur.ovs = 4'h0;
          if (rx_on && !cur.overrun_error_flag && cur.rx_q && !i_rx) begin
            next_cur.st = URX_START;
          end
        end
        URX_START: if (cur.ovs == OVS_HALF) begin
          next_cur.ovs = 4'h0;
          next_cur.nbit = 4'h0;
          next_cur.st = i_rx ? URX_IDLE : URX_DATA;
        end
        URX_DATA: if (cur.ovs == OVS_LAST) begin
          next_cur.shreg = {i_rx, cur.shreg[8:1]};
          next_cur.nbit = cur.nbit + 4'h1;
          if (cur.nbit + 4'h1 == (cur.rs[RS_NINE] ? BITS_9 : BITS_8)) begin
            next_cur.st = URX_STOP;
          end
        end
        URX_STOP: if (cur.ovs == OVS_LAST) begin
          next_cur.st = URX_IDLE;
          // align eight-bit characters to the low bits
          next_cur.shreg = cur.rs[RS_NINE] ? cur.shreg : {1'h0, cur.shreg[8:1]};
          keep = !(cur.rs[RS_NINE] && cur.rs[RS_ADDR_DET]) || cur.shreg[8];
          if (keep) begin
            push = 1'b1;
          end
        end
      endcase
    end
    // a full buffer with no read this cycle refuses the character
    if (push && cur.count == FIFO_DEPTH && !pop) begin
      next_cur.overrun_error_flag = 1'b1;
      push = 1'b0;
    end
    // write slot is oldest plus count, whether or not a read frees the head now
    if (push) begin
      next_cur.fifo[cur.rd_ptr ^ cur.count[0]] =
        {!i_rx, next_cur.shreg};
    end
    if (pop) begin
      next_cur.rd_ptr = !cur.rd_ptr;
    end
    next_cur.count = cur.count + {1'b0, push} - {1'b0, pop};
    // disabling the receiver clears overrun; disabling the port also empties the buffer
    if (!cur.rs[RS_RECV_EN]) begin
      next_cur.overrun_error_flag = 1'b0;
      next_cur.st = URX_IDLE;
    end
    if (!cur.rs[RS_PORT_EN]) begin
      next_cur.overrun_error_flag = 1'b0;
      next_cur.count = 2'h0;
      next_cur.rd_ptr = 1'b0;
      next_cur.st = URX_IDLE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cur <= '0;
      cur.ts <= TS_RST;
      cur.rx_q <= 1'b1;
    end else if (i_ce) begin
      cur <= next_cur;
    end
  end

  // =====================================================================
  // outputs
  assign o_rdata = cur.rdata;
  assign o_rx_pending = rx_on && (cur.count != 2'h0);
  assign o_rx_irq = o_rx_pending && cur.irq_en;

  // =====================================================================
  // assertions
  AST_OVR_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    cur.overrun_error_flag && cur.rs[RS_RECV_EN] && cur.rs[RS_PORT_EN] && i_ce |=> cur.overrun_error_flag)
    else $error("overrun flag dropped while enabled");
  AST_OVR_CLR: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && !cur.rs[RS_RECV_EN] |=> !cur.overrun_error_flag)
    else $error("overrun flag not cleared");
  AST_NO_RX_OVR: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    cur.overrun_error_flag && !pop && i_ce && cur.rs[RS_PORT_EN] |=> cur.count == $past(cur.count))
    else $error("buffer changed during overrun");
  AST_CNT_MAX: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    cur.count <= FIFO_DEPTH)
    else $error("buffer count above two");
  AST_PEND: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_rx_pending == (cur.rs[RS_RECV_EN] && cur.rs[RS_PORT_EN] && !cur.ts[TS_SYNC] && cur.count != 2'h0))
    else $error("pending flag mismatch");
  AST_IRQ: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_rx_irq |-> o_rx_pending && cur.irq_en)
    else $error("irq without cause");
  AST_ADDR: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    push && cur.rs[RS_NINE] && cur.rs[RS_ADDR_DET] |-> next_cur.shreg[8])
    else $error("non-address character accepted");
  AST_ABORT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && tick && cur.st == URX_START && cur.ovs == OVS_HALF && i_rx |=> cur.st == URX_IDLE && !cur.overrun_error_flag)
    else $error("false start not abandoned");
  AST_POP: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && pop && !push && cur.rs[RS_PORT_EN] |=> cur.count == $past(cur.count) - 2'h1)
    else $error("data read did not advance buffer");

  // =====================================================================
  // receive engine and read path checks
  AST_PEND_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !cur.rs[RS_RECV_EN] || !cur.rs[RS_PORT_EN] |-> !o_rx_pending)
    else $error("pending flag while receiver off");
  AST_PUSH_GROW: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && push && !pop && cur.rs[RS_PORT_EN] |=> cur.count == $past(cur.count) + 2'h1)
    else $error("received character not buffered");
  AST_OVR_SET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && tick && cur.st == URX_STOP && cur.ovs == OVS_LAST && keep && cur.count == FIFO_DEPTH
      && !pop && cur.rs[RS_RECV_EN] && cur.rs[RS_PORT_EN] |=> cur.overrun_error_flag)
    else $error("third character did not raise overrun");
  AST_FULL_KEEP: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && cur.count == FIFO_DEPTH && !pop && cur.rs[RS_PORT_EN] |=> cur.fifo == $past(cur.fifo))
    else $error("buffered character overwritten");
  AST_NO_START_OVR: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && cur.overrun_error_flag && cur.st == URX_IDLE |=> cur.st == URX_IDLE)
    else $error("reception started during overrun");
  AST_START_OK: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && tick && cur.st == URX_START && cur.ovs == OVS_HALF && !i_rx && cur.rs[RS_RECV_EN]
      && cur.rs[RS_PORT_EN] |=> cur.st == URX_DATA)
    else $error("valid start bit abandoned");
  AST_BIT_STEP: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && tick && cur.st == URX_DATA && cur.ovs != OVS_LAST && cur.rs[RS_RECV_EN] && cur.rs[RS_PORT_EN]
      |=> cur.nbit == $past(cur.nbit))
    else $error("shifter advanced between bit centres");
  AST_BIT_ADV: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && tick && cur.st == URX_DATA && cur.ovs == OVS_LAST && cur.rs[RS_RECV_EN] && cur.rs[RS_PORT_EN]
      |=> cur.nbit == $past(cur.nbit) + 4'h1)
    else $error("shifter missed a bit");
  AST_NINE_COUNT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && tick && cur.st == URX_DATA && cur.ovs == OVS_LAST && cur.nbit == BITS_8 - 4'h1
      && cur.rs[RS_NINE] && cur.rs[RS_RECV_EN] && cur.rs[RS_PORT_EN] |=> cur.st == URX_DATA)
    else $error("ninth data bit skipped");
  AST_STOP_GO: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && tick && cur.st == URX_STOP && cur.ovs == OVS_LAST |=> cur.st == URX_IDLE)
    else $error("receiver stuck after stop bit");
  AST_FILTER_DROP: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && tick && cur.st == URX_STOP && cur.ovs == OVS_LAST && cur.rs[RS_NINE] && cur.rs[RS_ADDR_DET]
      && !cur.shreg[8] |-> !push)
    else $error("data character passed the address filter");
  AST_PASS_ALL: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && tick && cur.st == URX_STOP && cur.ovs == OVS_LAST && !cur.rs[RS_ADDR_DET]
      && (cur.count != FIFO_DEPTH || pop) |-> push)
    else $error("character lost with address detect clear");
  AST_PORT_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && !cur.rs[RS_PORT_EN] |=> cur.count == 2'h0 && cur.st == URX_IDLE && !cur.overrun_error_flag)
    else $error("port disable did not reset the receiver");
  AST_RD_DATA: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && i_rd && i_addr == ADDR_RX_DATA |=> o_rdata == $past(head[7:0]))
    else $error("data read returned wrong byte");
  AST_RD_NINTH: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && i_rd && i_addr == ADDR_RX_STAT && cur.count != 2'h0 |=> o_rdata[RS_NINTH] == $past(head[8]))
    else $error("ninth bit status not from oldest character");
  AST_RD_FRAME: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && i_rd && i_addr == ADDR_RX_STAT && cur.count != 2'h0 |=> o_rdata[RS_FRAME_ERR] == $past(head[9]))
    else $error("framing status not from oldest character");
  AST_RD_OVR: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && i_rd && i_addr == ADDR_RX_STAT |=> o_rdata[RS_OVR_ERR] == $past(cur.overrun_error_flag))
    else $error("overrun status misreported");
  AST_RD_QUIET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && !i_rd |=> o_rdata == RST_BYTE)
    else $error("read data outside its cycle");

endmodule : urx_receiver

/* dv/urx_line_model.sv */
// remote serial transmitter driving the receive line
`timescale 1ns/1ps
module urx_line_model (
  input wire logic i_clk, // bench clock
  output logic o_line // serial line, idle high
);
  // 16 ticks of one clock each per bit
  localparam int BIT = 16;
  initial o_line = 1'b1;
  task automatic hold(input logic v, input int n);
    o_line <= v;
    repeat (n) @(posedge i_clk);
  endtask : hold
  // start, 8 or 9 data lsb first, stop, then idle gap
  task automatic send(input logic [8:0] d, input logic nine, input logic stop);
    hold(1'b0, BIT);
    for (int i = 0; i < (nine ? 9 : 8); i++) hold(d[i], BIT);
    hold(stop, BIT);
    hold(1'b1, 40);
  endtask : send
  // short low pulse that is not a start bit
  task automatic glitch();
    hold(1'b0, 4);
    hold(1'b1, 40);
  endtask : glitch
endmodule : urx_line_model

/* dv/urx_receiver_tb.sv */
// self-checking bench for the asynchronous receiver
`timescale 1ns/1ps
module urx_receiver_tb
  import urx_pkg::*;
;
  logic i_clk, i_rst_b, i_wr, i_rd, rx, o_rx_pending, o_rx_irq, ce;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, o_rdata;
  int failures, n_compared, cycles;
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  urx_receiver uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(ce), .i_rx(rx), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rx_pending(o_rx_pending),
    .o_rx_irq(o_rx_irq));
  urx_line_model line (.i_clk(i_clk), .o_line(rx));
  // ==========================================
  // helpers
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(what, o_rdata, exp);
  endtask : rd
  task automatic pend(input logic p, input logic q);
    #1;
    chk("pending", {7'h00, o_rx_pending}, {7'h00, p});
    chk("irq", {7'h00, o_rx_irq}, {7'h00, q});
  endtask : pend
  // ==========================================
  // scenarios
  task automatic t_basic();
    line.send(9'h05a, 1'b0, 1'b1);
    pend(1'b1, 1'b1);
    @(posedge i_clk);
    ce <= 1'b0;
    rd(ADDR_RX_DATA, 8'h00, "frozen read");
    @(posedge i_clk);
    ce <= 1'b1;
    pend(1'b1, 1'b1);
    rd(ADDR_RX_STAT, 8'h90, "status");
    rd(ADDR_RX_DATA, 8'h5a, "data");
    pend(1'b0, 1'b0);
  endtask : t_basic
  task automatic t_frame();
    line.send(9'h0c3, 1'b0, 1'b0);
    rd(ADDR_RX_STAT, 8'h94, "framing");
    rd(ADDR_RX_DATA, 8'hc3, "data");
    line.glitch();
    pend(1'b0, 1'b0);
    rd(3'h7, 8'h00, "unmapped");
  endtask : t_frame
  task automatic t_overrun();
    line.send(9'h0a1, 1'b0, 1'b1);
    line.send(9'h0b2, 1'b0, 1'b1);
    line.send(9'h0c3, 1'b0, 1'b1);
    pend(1'b1, 1'b1);
    rd(ADDR_RX_STAT, 8'h92, "overrun");
    line.send(9'h0d4, 1'b0, 1'b1);
    rd(ADDR_RX_DATA, 8'ha1, "first");
    rd(ADDR_RX_DATA, 8'hb2, "second");
    pend(1'b0, 1'b0);
    rd(ADDR_RX_STAT, 8'h92, "overrun kept");
    wr(ADDR_RX_STAT, 8'h80);
    rd(ADDR_RX_STAT, 8'h80, "overrun cleared");
    wr(ADDR_RX_STAT, 8'h90);
    line.send(9'h066, 1'b0, 1'b1);
    rd(ADDR_RX_DATA, 8'h66, "resumed");
  endtask : t_overrun
  task automatic t_port_off();
    line.send(9'h011, 1'b0, 1'b1);
    line.send(9'h022, 1'b0, 1'b1);
    line.send(9'h033, 1'b0, 1'b1);
    rd(ADDR_RX_STAT, 8'h92, "overrun again");
    wr(ADDR_RX_STAT, 8'h10);
    rd(ADDR_RX_STAT, 8'h10, "port off");
    wr(ADDR_RX_STAT, 8'h90);
    pend(1'b0, 1'b0);
  endtask : t_port_off
  task automatic t_addr();
    wr(ADDR_RX_STAT, 8'h80);
    wr(ADDR_RX_STAT, 8'hc0);
    wr(ADDR_RX_STAT, 8'hc8);
    wr(ADDR_RX_STAT, 8'hd8);
    line.send(9'h033, 1'b1, 1'b1);
    pend(1'b0, 1'b0);
    line.send(9'h112, 1'b1, 1'b1);
    pend(1'b1, 1'b1);
    rd(ADDR_RX_STAT, 8'hd9, "ninth bit");
    rd(ADDR_RX_DATA, 8'h12, "address");
    wr(ADDR_RX_STAT, 8'hd0);
    wr(ADDR_IRQ_EN, 8'h00);
    line.send(9'h077, 1'b1, 1'b1);
    pend(1'b1, 1'b0);
    rd(ADDR_RX_STAT, 8'hd0, "ninth bit low");
    rd(ADDR_RX_DATA, 8'h77, "payload");
    wr(ADDR_RX_STAT, 8'hd8);
    wr(ADDR_IRQ_EN, 8'h01);
  endtask : t_addr
  // ==========================================
  // main sequence and timeout
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    {i_rst_b, i_wr, i_rd, i_addr, i_wdata} = '0;
    ce = 1'b1;
    {failures, n_compared, cycles} = '0;
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'b1;
    pend(1'b0, 1'b0);
    rd(ADDR_RX_STAT, 8'h00, "status reset");
    rd(ADDR_TX_STAT, 8'h02, "tx status reset");
    wr(ADDR_DIV_LO, 8'h00);
    wr(ADDR_BAUD_CTRL, 8'h08);
    wr(ADDR_TX_STAT, 8'h00);
    wr(ADDR_RX_STAT, 8'h80);
    wr(ADDR_IRQ_EN, 8'h01);
    wr(ADDR_RX_STAT, 8'h90);
    rd(ADDR_BAUD_CTRL, 8'h48, "baud ctrl");
    t_basic();
    t_frame();
    t_overrun();
    t_port_off();
    t_addr();
    wrap_up();
  end
endmodule : urx_receiver_tb
